// >>> logic/adcf_top.sv
// converter format control with a classic wishbone register slave
module adcf_top
   import adcf_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   input  wire logic [9:0]  conversion_data_i,
   output logic             converter_enable_o,
   output logic             conversion_busy_o,
   output logic             hold_capacitor_o,
   output logic [1:0]       positive_reference_select_o,
   output logic             negative_reference_select_o,
   output logic [2:0]       conversion_clock_select_o
);

   adcf_ctrl_t  ctrl;
   adcf_state_t state;
   adcf_state_t next_state;
   logic [7:0]  result_high;
   logic [7:0]  result_low;
   logic        enable;
   logic        go;
   logic        conv_done;
   logic        bus_req;
   logic        wr_strobe;
   logic        wr_ctrl;
   logic        wr_run;
   logic        wr_high;
   logic        wr_low;
   logic [7:0]  ctrl_read;

   // a request is taken once, in the cycle before ack
   assign bus_req   = cyc_i && stb_i && !ack_o;
   assign wr_strobe = bus_req && we_i && sel_i[0];
   assign wr_ctrl   = wr_strobe && (adr_i == ADCF_OFF_CTRL);
   assign wr_high   = wr_strobe && (adr_i == ADCF_OFF_RES_HIGH);
   assign wr_low    = wr_strobe && (adr_i == ADCF_OFF_RES_LOW);
   assign wr_run    = wr_strobe && (adr_i == ADCF_OFF_RUN);

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= bus_req;
      end
   end

   // control register; the unimplemented bit is never stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= adcf_ctrl_t'(ADCF_CTRL_RESET); // [R8]
      end else if (wr_ctrl) begin
         ctrl             <= adcf_ctrl_t'(dat_i[7:0]); // [R11]
         ctrl.unused_zero <= 1'b0; // [R8]
      end
   end

   assign ctrl_read = {ctrl[7:4], 1'b0, ctrl[2:0]}; // [R8]

   // enable bit; clearing it cancels any running conversion
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable <= 1'b0;
      end else if (wr_run) begin
         enable <= dat_i[ADCF_RUN_ENABLE_BIT];
      end
   end

   // status bit: software sets it, completion clears it, a set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         go <= 1'b0;
      end else if (wr_run) begin
         go <= dat_i[ADCF_RUN_GO_BIT] && dat_i[ADCF_RUN_ENABLE_BIT]; // [R9] [R10]
      end else if (!enable || conv_done) begin
         go <= 1'b0; // [R9] [R10]
      end
   end

   // sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         ADCF_IDLE: begin
            if (go && enable) begin
               next_state = ADCF_CONVERT;
            end
         end
         ADCF_CONVERT: begin
            if (!go || !enable) begin
               next_state = ADCF_IDLE; // [R10]
            end else if (conv_done) begin
               next_state = ADCF_FINISH;
            end
         end
         ADCF_FINISH: begin
            next_state = ADCF_IDLE;
         end
         default: begin
            next_state = ADCF_IDLE;
         end
      endcase
   end

   // sequencer state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ADCF_IDLE;
      end else begin
         state <= next_state;
      end
   end

   adcf_tad_timer adcf_tad_timer_i (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .run_i          (state == ADCF_CONVERT && go && enable),
      .clock_select_i (ctrl.conversion_clock_select),
      .conv_done_o    (conv_done)
   );

   // result bytes: no reset so their contents survive a reset
   always_ff @(posedge clk_i) begin
      if (conv_done && ctrl.result_justify_select) begin
         result_high <= {6'h00, conversion_data_i[9:8]}; // [R3]
      end else if (conv_done) begin
         result_high <= conversion_data_i[9:2]; // [R1]
      end else if (wr_high) begin
         result_high <= dat_i[7:0]; // [R7]
      end
   end

   always_ff @(posedge clk_i) begin
      if (conv_done && ctrl.result_justify_select) begin
         result_low <= conversion_data_i[7:0]; // [R4]
      end else if (conv_done) begin
         result_low <= {conversion_data_i[1:0], 6'h00}; // [R2]
      end else if (wr_low) begin
         result_low <= dat_i[7:0]; // [R7]
      end
   end

   // registered read data; unmapped offsets read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (bus_req && !we_i) begin
         case (adr_i)
            ADCF_OFF_CTRL:     dat_o <= {24'h00_0000, ctrl_read};
            ADCF_OFF_RES_HIGH: dat_o <= {24'h00_0000, result_high};
            ADCF_OFF_RES_LOW:  dat_o <= {24'h00_0000, result_low};
            ADCF_OFF_RUN:      dat_o <= {30'h0000_0000, go, enable};
            default:           dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // outputs toward the analog front end
   assign converter_enable_o          = enable;
   assign conversion_busy_o           = go;
   assign hold_capacitor_o            = (state == ADCF_CONVERT);
   assign positive_reference_select_o = ctrl.positive_reference_select;
   assign negative_reference_select_o = ctrl.negative_reference_select;
   assign conversion_clock_select_o   = ctrl.conversion_clock_select;

   // checks
   a_left_high_byte: assert property (@(posedge clk_i) // [R1]
      conv_done && !ctrl.result_justify_select |=>
      result_high == $past(conversion_data_i[9:2]))
      else $error("left justified high byte wrong");

   a_left_low_byte: assert property (@(posedge clk_i) // [R2]
      conv_done && !ctrl.result_justify_select |=>
      result_low[7:6] == $past(conversion_data_i[1:0]))
      else $error("left justified low byte wrong");

   a_right_high_byte: assert property (@(posedge clk_i) // [R3]
      conv_done && ctrl.result_justify_select |=>
      result_high[1:0] == $past(conversion_data_i[9:8]))
      else $error("right justified high byte wrong");

   a_right_low_byte: assert property (@(posedge clk_i) // [R4]
      conv_done && ctrl.result_justify_select |=>
      result_low == $past(conversion_data_i[7:0]))
      else $error("right justified low byte wrong");

   a_result_kept_reset: assert property (@(posedge clk_i) // [R7]
      rst_i |=> $stable(result_high) && $stable(result_low))
      else $error("result changed by reset");

   a_ctrl_bit_three: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
      ack_o && !we_i && $past(adr_i) == ADCF_OFF_CTRL |-> !dat_o[3])
      else $error("control bit 3 read as one");

   a_ctrl_reset_zero: assert property (@(posedge clk_i) // [R8]
      rst_i |=> ctrl == adcf_ctrl_t'(ADCF_CTRL_RESET) && !go && !enable)
      else $error("control not cleared by reset");

   a_go_auto_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
      conv_done && !wr_run |=> !go ##1 state == ADCF_IDLE)
      else $error("status bit not cleared at completion");

   a_go_holds_busy: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
      go && enable && !conv_done && !wr_run |=> go)
      else $error("status bit dropped early");

   a_disabled_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
      !enable && !wr_run |=> !go ##1 !hold_capacitor_o)
      else $error("converter active while disabled");

   a_ctrl_write_kept: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
      wr_ctrl |=> ctrl_read == {$past(dat_i[7:4]), 1'b0, $past(dat_i[2:0])})
      else $error("control write not stored");

   a_ctrl_only_written: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
      !wr_ctrl |=> $stable(ctrl))
      else $error("control changed without a write");

   a_enable_only_written: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
      !wr_run |=> $stable(enable))
      else $error("enable changed without a write");

   a_go_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
      go |-> enable)
      else $error("status bit set while disabled");

   a_hold_ends: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
      hold_capacitor_o && !(go && enable) |=> !hold_capacitor_o)
      else $error("hold kept after stop");

   a_start_converts: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
      state == ADCF_IDLE && go && enable |=> hold_capacitor_o)
      else $error("conversion did not start");

   a_done_in_convert: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
      conv_done |-> state == ADCF_CONVERT)
      else $error("completion outside a conversion");

   a_finish_to_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
      state == ADCF_FINISH |=> state == ADCF_IDLE)
      else $error("sequencer stuck after completion");

   a_write_high_byte: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      wr_high && !conv_done |=> result_high == $past(dat_i[7:0]))
      else $error("high result byte write lost");

   a_write_low_byte: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      wr_low && !conv_done |=> result_low == $past(dat_i[7:0]))
      else $error("low result byte write lost");

   a_read_high_byte: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      bus_req && !we_i && adr_i == ADCF_OFF_RES_HIGH |=> dat_o[7:0] == $past(result_high))
      else $error("high result byte read wrong");

   a_read_low_byte: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      bus_req && !we_i && adr_i == ADCF_OFF_RES_LOW |=> dat_o[7:0] == $past(result_low))
      else $error("low result byte read wrong");

   a_read_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_req && !we_i && adr_i[1:0] != 2'h0 |=> dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_read_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o && !we_i |-> dat_o[31:8] == 24'h00_0000)
      else $error("upper read lanes not zero");

   a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");

   a_ack_after_request: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_req |=> ack_o)
      else $error("request not acknowledged");

   a_ack_only_request: assert property (@(posedge clk_i) disable iff (rst_i)
      !bus_req |=> !ack_o)
      else $error("ack without a request");

   a_bus_reset_clear: assert property (@(posedge clk_i)
      rst_i |=> dat_o == 32'h0000_0000 && !ack_o)
      else $error("bus outputs not cleared by reset");

   c_left_done: cover property (@(posedge clk_i) conv_done && !ctrl.result_justify_select);
   c_right_done: cover property (@(posedge clk_i) conv_done && ctrl.result_justify_select);
   c_abort: cover property (@(posedge clk_i) state == ADCF_CONVERT ##1 state == ADCF_IDLE);
   c_restart_same_cycle: cover property (@(posedge clk_i) conv_done && wr_run);
   c_sw_result_write: cover property (@(posedge clk_i) wr_high || wr_low);

endmodule

// >>> logic/adcf_pkg.sv
// Functional notes
// R1: left justified: result bits 9..2 fill the whole high result byte.
// R2: left justified: result bits 1..0 go to low byte bits 7..6.
// R3: right justified: result bits 9..8 go to high byte bits 1..0.
// R4: right justified: result bits 7..0 fill the whole low result byte.
// R5: software must ignore reserved result bit positions.
// R6: software waits a full acquisition time after changing channel before starting.
// R7: result bytes are read/write, unset at power-on, kept over other resets.
// R8: control bit 3 reads zero; other control bits reset to zero.
// R9: software sets the status bit to start; hardware clears it at completion.
// R10: enable bit clear keeps the converter disabled and idle.
// R11: control holds clock select 6..4, negative ref bit 2, positive ref 1..0.
package adcf_pkg;

   // register byte offsets on the bus
   localparam logic [3:0] ADCF_OFF_CTRL     = 4'h0;
   localparam logic [3:0] ADCF_OFF_RES_HIGH = 4'h4;
   localparam logic [3:0] ADCF_OFF_RES_LOW  = 4'h8;
   localparam logic [3:0] ADCF_OFF_RUN      = 4'hc;

   // run register field positions
   localparam int ADCF_RUN_ENABLE_BIT = 0;
   localparam int ADCF_RUN_GO_BIT     = 1;

   // reset values
   localparam logic [7:0] ADCF_CTRL_RESET = 8'h00;

   // positive reference codes
   localparam logic [1:0] ADCF_PREF_SUPPLY   = 2'h0;
   localparam logic [1:0] ADCF_PREF_RESERVED = 2'h1;
   localparam logic [1:0] ADCF_PREF_PIN      = 2'h2;
   localparam logic [1:0] ADCF_PREF_FIXED    = 2'h3;

   // conversion timing: clock divisors and length in conversion clocks
   localparam logic [6:0] ADCF_DIV_2   = 7'h02;
   localparam logic [6:0] ADCF_DIV_4   = 7'h04;
   localparam logic [6:0] ADCF_DIV_8   = 7'h08;
   localparam logic [6:0] ADCF_DIV_16  = 7'h10;
   localparam logic [6:0] ADCF_DIV_32  = 7'h20;
   localparam logic [6:0] ADCF_DIV_64  = 7'h40;
   localparam logic [6:0] ADCF_DIV_RC  = 7'h10;
   localparam logic [3:0] ADCF_CONV_TADS = 4'hb;

   // cycles software lets the hold capacitor settle before it starts a conversion
   localparam int ADCF_ACQ_CYCLES = 32'h0000_0032;

   // control register layout
   typedef struct packed {
      logic       result_justify_select;
      logic [2:0] conversion_clock_select;
      logic       unused_zero;
      logic       negative_reference_select;
      logic [1:0] positive_reference_select;
   } adcf_ctrl_t;

   // conversion sequencer states, gray along idle -> convert -> finish
   typedef enum logic [1:0] {
      ADCF_IDLE    = 2'b00,
      ADCF_CONVERT = 2'b01,
      ADCF_FINISH  = 2'b11
   } adcf_state_t;

   // conversion clock divisor for a clock select code
   function automatic logic [6:0] adcf_divisor(input logic [2:0] sel);
      logic [6:0] d;
      d = ADCF_DIV_2;
      case (sel)
         3'h0: d = ADCF_DIV_2;
         3'h1: d = ADCF_DIV_8;
         3'h2: d = ADCF_DIV_32;
         3'h4: d = ADCF_DIV_4;
         3'h5: d = ADCF_DIV_16;
         3'h6: d = ADCF_DIV_64;
         default: d = ADCF_DIV_RC;
      endcase
      return d;
   endfunction

endpackage

// >>> logic/adcf_tad_timer.sv
// counts conversion clock periods while a conversion runs
module adcf_tad_timer
   import adcf_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       run_i,
   input  wire logic [2:0] clock_select_i,
   output logic            conv_done_o
);

   logic [6:0] div_count;
   logic [3:0] tad_count;
   logic       tad_tick;

   // one tick per conversion clock period
   assign tad_tick = run_i && (div_count == adcf_divisor(clock_select_i) - 7'h01);

   // divider restarts whenever the conversion is not running
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i || tad_tick) begin
         div_count <= 7'h00;
      end else begin
         div_count <= div_count + 7'h01;
      end
   end

   // period counter and completion pulse
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         tad_count   <= 4'h0;
         conv_done_o <= 1'b0;
      end else begin
         conv_done_o <= 1'b0;
         if (tad_tick) begin
            if (tad_count == ADCF_CONV_TADS - 4'h1) begin
               tad_count   <= 4'h0;
               conv_done_o <= 1'b1;
            end else begin
               tad_count <= tad_count + 4'h1;
            end
         end
      end
   end

endmodule

// >>> tb/test_adcf_top.sv
module test_adcf_top
   import adcf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [3:0]  adr_i = 4'h0;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [9:0]  conversion_data_i = 10'h0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        converter_enable_o;
   logic        conversion_busy_o;
   logic        hold_capacitor_o;
   logic [1:0]  positive_reference_select_o;
   logic        negative_reference_select_o;
   logic [2:0]  conversion_clock_select_o;
   int          failures = 0;
   int          n_tests  = 0;
   int          cycles   = 0;
   logic [31:0] rd;
   logic [7:0]  v;
   logic [7:0]  hi;
   logic [9:0]  d;
   int          n;

   adcf_top adcf_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .conversion_data_i(conversion_data_i),
      .converter_enable_o(converter_enable_o), .conversion_busy_o(conversion_busy_o),
      .hold_capacitor_o(hold_capacitor_o),
      .positive_reference_select_o(positive_reference_select_o),
      .negative_reference_select_o(negative_reference_select_o),
      .conversion_clock_select_o(conversion_clock_select_o));

   // free running clock
   always #5 clk_i = ~clk_i;

   // cuts a hang short
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         failures = failures + 1;
         report_and_stop();
      end
   end

   // expected low byte and high byte for a justify choice
   function automatic logic [7:0] exp_high(input logic j, input logic [9:0] x);
      return j ? {6'h0, x[9:8]} : x[9:2];
   endfunction
   function automatic logic [7:0] exp_low(input logic j, input logic [9:0] x);
      return j ? x[7:0] : {x[1:0], 6'h0};
   endfunction
   // conversion clock periods in system clocks
   function automatic int exp_div(input logic [2:0] s);
      int t[8] = '{2, 8, 32, 16, 4, 16, 64, 16};
      return t[s];
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one classic wishbone cycle, waits for ack
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= 4'hf;
      dat_i <= wd;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   task automatic do_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      void'($urandom(32'hd81c56b0));
      do_reset();
      // reset values and an unmapped address
      bus(1'b0, ADCF_OFF_CTRL, 32'h0);
      check(rd, 32'h0);
      bus(1'b0, ADCF_OFF_RUN, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, 4'h1, 32'hff);
      bus(1'b0, 4'h1, 32'h0);
      check(rd, 32'h0);
      $display("test reset values done");
      // go without enable leaves converter idle
      bus(1'b1, ADCF_OFF_RUN, 32'h2);
      @(posedge clk_i);
      check({conversion_busy_o, hold_capacitor_o, converter_enable_o}, 3'b000);
      $display("test disabled go done");
      // every clock select, both justifications, random fields and data
      for (int k = 0; k < 8; k++) begin
         v = 8'($urandom);
         v[7] = k[0];
         v[6:4] = 3'(k);
         d = 10'($urandom);
         if (k == 6) d = 10'h3ff;
         bus(1'b1, ADCF_OFF_CTRL, {24'h0, v});
         bus(1'b0, ADCF_OFF_CTRL, 32'h0);
         check(rd, {24'h0, v & 8'hf7});
         check({conversion_clock_select_o, negative_reference_select_o,
                positive_reference_select_o}, {v[6:4], v[2:0]});
         conversion_data_i <= d;
         repeat (ADCF_ACQ_CYCLES) @(posedge clk_i);
         bus(1'b1, ADCF_OFF_RUN, 32'h3);
         check(conversion_busy_o, 1'b1);
         @(posedge clk_i);
         check(hold_capacitor_o, 1'b1);
         n = 2;
         while (conversion_busy_o === 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
         end
         check(n >= 11 * exp_div(v[6:4]) && n <= 11 * exp_div(v[6:4]) + 4, 1'b1);
         bus(1'b0, ADCF_OFF_RUN, 32'h0);
         check(rd, 32'h1);
         bus(1'b0, ADCF_OFF_RES_HIGH, 32'h0);
         check(rd, {24'h0, exp_high(v[7], d)});
         hi = rd[7:0];
         bus(1'b0, ADCF_OFF_RES_LOW, 32'h0);
         check(rd, {24'h0, exp_low(v[7], d)});
         check(v[7] ? {hi[1:0], rd[7:0]} : {hi, rd[7:6]}, d);
      end
      $display("test conversions done");
      // a running conversion is cut short by clearing go, then by clearing enable
      bus(1'b1, ADCF_OFF_CTRL, 32'h60);
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, ADCF_OFF_RUN, 32'h3);
         repeat (20) @(posedge clk_i);
         bus(1'b1, ADCF_OFF_RUN, k ? 32'h0 : 32'h1);
         @(posedge clk_i);
         check({conversion_busy_o, hold_capacitor_o, converter_enable_o},
               {2'b00, k == 0});
      end
      $display("test abort done");
      // result bytes writable and kept over reset, control cleared
      bus(1'b1, ADCF_OFF_RES_HIGH, 32'ha5);
      bus(1'b1, ADCF_OFF_RES_LOW, 32'h5a);
      bus(1'b1, ADCF_OFF_RUN, 32'h1);
      do_reset();
      bus(1'b0, ADCF_OFF_RES_HIGH, 32'h0);
      check(rd, 32'ha5);
      bus(1'b0, ADCF_OFF_RES_LOW, 32'h0);
      check(rd, 32'h5a);
      bus(1'b0, ADCF_OFF_CTRL, 32'h0);
      check(rd, 32'h0);
      check(converter_enable_o, 1'b0);
      $display("test result storage done");
      report_and_stop();
   end
endmodule
